// ### core/ctu_pkg.sv
//----------------------------------------------------------------------
// Charge time unit edge control: shared constants
//----------------------------------------------------------------------
// Behaviour
// - Ordered mode: edge two waits for edge one
// - Unordered mode: both edges accepted independently
// - Discharge bit grounds the current source output
// - Discharge plus sampling connects the sink
// - Edges set flags; software writes flags too
// - Edge enable picks hardware or software edges
// - Four-bit source codes select the edge inputs
// - Idle stop halts the unit in idle
package ctu_pkg;

    //------------------------------------------------------------------
    // Register byte offsets
    //------------------------------------------------------------------
    localparam logic [7:0] CTU_CTRL_OFF = 8'h00;     // Control
    localparam logic [7:0] CTU_EDGE_OFF = 8'h04;     // Edge configuration
    localparam logic [7:0] CTU_STAT_OFF = 8'h08;     // Interrupt status
    localparam logic [7:0] CTU_CLR_OFF = 8'h0c;      // Interrupt clear
    localparam logic [7:0] CTU_IEN_OFF = 8'h10;      // Interrupt enable

    //------------------------------------------------------------------
    // Control register fields
    //------------------------------------------------------------------
    localparam int CTU_UNIT_ENABLE_BIT = 15;
    localparam int CTU_IDLE_STOP_BIT = 13;
    localparam int CTU_DELAY_GEN_BIT = 12;
    localparam int CTU_HW_EDGE_BIT = 11;
    localparam int CTU_ORDER_BIT = 10;
    localparam int CTU_GROUND_BIT = 9;
    localparam int CTU_CONV_REQ_BIT = 8;
    localparam logic [15:0] CTU_CTRL_WMASK = 16'hbf00;
    localparam logic [15:0] CTU_CTRL_RST = 16'h0000;

    //------------------------------------------------------------------
    // Edge configuration fields (per-edge field base: sel, pol, mode)
    //------------------------------------------------------------------
    localparam int CTU_E1_BASE = 10;                 // Edge one source lsb
    localparam int CTU_E2_BASE = 2;                  // Edge two source lsb
    localparam int CTU_POL_OFS = 4;                  // Polarity above sel
    localparam int CTU_MOD_OFS = 5;                  // Sampling kind above
    localparam int CTU_FLAG1_BIT = 8;
    localparam int CTU_FLAG2_BIT = 9;
    localparam logic [15:0] CTU_EDGE_WMASK = 16'hfffc;
    localparam logic [15:0] CTU_EDGE_RST = 16'h0000;

    //------------------------------------------------------------------
    // Edge source codes
    //------------------------------------------------------------------
    localparam logic [3:0] CTU_SRC_INSTR_CLK = 4'hf;
    localparam logic [3:0] CTU_SRC_CMP = 4'h4;
    localparam logic [3:0] CTU_SRC_PIN_A = 4'h3;
    localparam logic [3:0] CTU_SRC_PIN_B = 4'h2;
    localparam logic [3:0] CTU_SRC_OC = 4'h1;

    //------------------------------------------------------------------
    // Interrupt events
    //------------------------------------------------------------------
    localparam int CTU_EV_EDGE1 = 0;
    localparam int CTU_EV_EDGE2 = 1;
    localparam int CTU_EV_DONE = 2;
    localparam logic [2:0] CTU_IRQ_RST = 3'h0;

endpackage

// ### core/ctu_edge_ctrl.sv
`timescale 1ns/1ps
module ctu_edge_ctrl
    import ctu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Edge sources
    input wire logic edge_pin_one,
    input wire logic edge_pin_two,
    input wire logic first_comparator,
    input wire logic first_output_compare,
    // Device state and converter status
    input wire logic idle_mode,
    input wire logic adc_sampling,
    // Analog controls and requests
    output logic current_source_on,
    output logic source_ground,
    output logic discharge_sink,
    output logic conv_start,
    output logic delay_gen_mode,
    output logic irq
);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    logic [15:0] ctrl_q, ctrl_d;             // Control register
    logic [15:0] edge_q, edge_d;             // Edge configuration
    logic [2:0] stat_q, stat_d;              // Sticky event status
    logic [2:0] ien_q, ien_d;                // Interrupt enable
    logic [1:0] act_prev_q, act_prev_d;      // Last active level per edge
    logic done_q, done_d;                    // Both edges seen
    logic instr_q, instr_d;                  // Instruction clock image
    // Bus answer registers
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    // Output drivers
    logic src_on_q, src_on_d;
    logic ground_q, ground_d;
    logic sink_q, sink_d;
    logic conv_q, conv_d;
    logic irq_q, irq_d;

    logic [1:0] act;                         // Selected source, polarised
    logic [1:0] hit;                         // Raw edge event per edge

    //------------------------------------------------------------------
    // Per-edge source select, polarity and sampling kind
    //------------------------------------------------------------------
    // One copy per edge; edge two has its own pin order
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_edge
            localparam int BASE = (gi == 0) ? CTU_E1_BASE : CTU_E2_BASE;
            logic [3:0] sel;
            logic raw;
            assign sel = edge_q[BASE+3:BASE];
            // Source multiplexer; pins swap between edges
            always_comb
            begin
                case (sel)
                    CTU_SRC_INSTR_CLK: raw = instr_q;
                    CTU_SRC_CMP: raw = (gi == 1) ? first_comparator
                                                 : 1'b0;
                    CTU_SRC_PIN_A: raw = (gi == 0) ? edge_pin_one
                                                   : edge_pin_two;
                    CTU_SRC_PIN_B: raw = (gi == 0) ? edge_pin_two
                                                   : edge_pin_one;
                    CTU_SRC_OC: raw = first_output_compare;
                    default: raw = 1'b0;                        // Reserved
                endcase
            end
            // Polarity: set means rising or high is active
            assign act[gi] = edge_q[BASE+CTU_POL_OFS] ? raw : ~raw;
            // Edge kind (mode bit set) fires on activation only;
            // level kind (mode bit clear) fires every active cycle
            assign hit[gi] = edge_q[BASE+CTU_MOD_OFS]
                           ? (act[gi] & ~act_prev_q[gi]) : act[gi];
        end
    endgenerate

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    // Decoded conditions shared by the branches below
    logic run;
    logic hw_en;
    logic ev1;
    logic ev2;
    logic meas_end;
    logic wr_acc;
    logic unmapped;
    always_comb
    begin
        // Hold control, edge, status and enable unless something below changes them
        ctrl_d = ctrl_q;
        edge_d = edge_q;
        stat_d = stat_q;
        ien_d = ien_q;
        prdata_d = 32'h0000_0000;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        instr_d = ~instr_q;

        // Unit runs when enabled and not stopped by idle
        run = ctrl_q[CTU_UNIT_ENABLE_BIT]
            & ~(ctrl_q[CTU_IDLE_STOP_BIT] & idle_mode);
        hw_en = ctrl_q[CTU_HW_EDGE_BIT];
        // Edge history is dropped while the unit is stopped
        act_prev_d = run ? act : 2'b00;

        // Setup phase: decode address, answer in the access phase
        unmapped = !(paddr == CTU_CTRL_OFF || paddr == CTU_EDGE_OFF
                  || paddr == CTU_STAT_OFF || paddr == CTU_CLR_OFF
                  || paddr == CTU_IEN_OFF);
        if (psel && !penable)
        begin
            pready_d = 1'b1;
            pslverr_d = unmapped;
            case (paddr)
                CTU_CTRL_OFF: prdata_d = {16'h0000, ctrl_q};
                CTU_EDGE_OFF: prdata_d = {16'h0000, edge_q};
                CTU_STAT_OFF: prdata_d = {29'h0000_0000, stat_q};
                CTU_IEN_OFF: prdata_d = {29'h0000_0000, ien_q};
                default: prdata_d = 32'h0000_0000;   // Clear reads zero
            endcase
        end

        // Access phase completes on this edge
        wr_acc = psel && penable && pready_q && pwrite && !pslverr_q;
        if (wr_acc)
        begin
            case (paddr)
                CTU_CTRL_OFF: ctrl_d = pwdata[15:0] & CTU_CTRL_WMASK;
                // Flag bits written here drive edges by hand
                CTU_EDGE_OFF: edge_d = pwdata[15:0]
                                     & CTU_EDGE_WMASK;
                CTU_CLR_OFF: stat_d = stat_q & ~pwdata[2:0];
                CTU_IEN_OFF: ien_d = pwdata[2:0];
                default: ;
            endcase
        end

        // Hardware edges only when edge enable is set
        ev1 = run && hw_en && hit[0];
        // Ordered mode holds off edge two until edge one
        ev2 = run && hw_en && hit[1]
            && (!ctrl_q[CTU_ORDER_BIT]
                || edge_q[CTU_FLAG1_BIT]);

        // Hardware set wins over a same-cycle software clear
        if (ev1)
        begin
            edge_d[CTU_FLAG1_BIT] = 1'b1;
        end
        if (ev2)
        begin
            edge_d[CTU_FLAG2_BIT] = 1'b1;
        end

        // Measurement ends when both flags stand
        done_d = edge_q[CTU_FLAG1_BIT] & edge_q[CTU_FLAG2_BIT];
        meas_end = done_d & ~done_q;

        // Sticky events, set after clear so set wins
        if (ev1)
        begin
            stat_d[CTU_EV_EDGE1] = 1'b1;
        end
        if (ev2)
        begin
            stat_d[CTU_EV_EDGE2] = 1'b1;
        end
        if (meas_end)
        begin
            stat_d[CTU_EV_DONE] = 1'b1;
        end

        // Conversion request only with the trigger bit
        conv_d = meas_end & run & ctrl_q[CTU_CONV_REQ_BIT];
        // Ground the current source while discharging
        ground_d = ctrl_d[CTU_GROUND_BIT];
        // Sink reaches sample capacitors only while sampling
        sink_d = ctrl_d[CTU_GROUND_BIT] & adc_sampling;
        // Current flows from edge one until edge two
        src_on_d = run & edge_d[CTU_FLAG1_BIT]
                 & ~edge_d[CTU_FLAG2_BIT] & ~ctrl_d[CTU_GROUND_BIT];
        // Level interrupt from enabled sticky bits
        irq_d = |(stat_d & ien_d);
    end

    //------------------------------------------------------------------
    // Software-visible registers
    //------------------------------------------------------------------
    // Control, edge configuration and interrupt state
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ctrl_q <= CTU_CTRL_RST;
            edge_q <= CTU_EDGE_RST;
            stat_q <= CTU_IRQ_RST;
            ien_q <= CTU_IRQ_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            edge_q <= edge_d;
            stat_q <= stat_d;
            ien_q <= ien_d;
        end
    end

    //------------------------------------------------------------------
    // Edge tracking
    //------------------------------------------------------------------
    // Previous active levels, measurement state, internal clock image
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            act_prev_q <= 2'b00;
            done_q <= 1'b0;
            instr_q <= 1'b0;
        end
        else
        begin
            act_prev_q <= act_prev_d;
            done_q <= done_d;
            instr_q <= instr_d;
        end
    end

    //------------------------------------------------------------------
    // Bus answer
    //------------------------------------------------------------------
    // Ready, error and read data stand for the access cycle only
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    //------------------------------------------------------------------
    // Output drivers
    //------------------------------------------------------------------
    // Analog controls, conversion request and interrupt line
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            src_on_q <= 1'b0;
            ground_q <= 1'b0;
            sink_q <= 1'b0;
            conv_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            src_on_q <= src_on_d;
            ground_q <= ground_d;
            sink_q <= sink_d;
            conv_q <= conv_d;
            irq_q <= irq_d;
        end
    end

    //------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    //------------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign current_source_on = src_on_q;
    assign source_ground = ground_q;
    assign discharge_sink = sink_q;
    assign conv_start = conv_q;
    // Delay mode expects comparator on edge two; shown to analog side
    assign delay_gen_mode = ctrl_q[CTU_DELAY_GEN_BIT];
    assign irq = irq_q;

endmodule

// ### dv/ctu_edge_ctrl_properties.sv
`timescale 1ns/1ps
module ctu_edge_ctrl_properties
    import ctu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic adc_sampling,
    input wire logic current_source_on,
    input wire logic source_ground,
    input wire logic discharge_sink,
    input wire logic conv_start,
    input wire logic delay_gen_mode
);
    //------------------------------------------------------------
    // Helper logic and properties
    //------------------------------------------------------------
    // Control register write completing at this edge
    wire ctrl_wr = psel && penable && pready && pwrite
        && (paddr == CTU_CTRL_OFF);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_access_follows: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_conv_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("conversion request too long");
    a_sink_grounded: assert property (discharge_sink |->
        source_ground && $past(adc_sampling))
        else $error("sink on without ground and sampling");
    a_ground_by_write: assert property ($changed(source_ground) |->
        $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("ground moved without write");
    a_ground_stops: assert property (source_ground [*2] |->
        !current_source_on)
        else $error("source on while grounded");
    a_delay_by_write: assert property ($rose(delay_gen_mode) |->
        $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("delay mode rose without write");

    c_conv: cover property (conv_start);
    c_sink: cover property (discharge_sink);
    c_err: cover property (pslverr);
endmodule

// ### dv/ctu_edge_ctrl_test.sv
`timescale 1ns/1ps
module ctu_edge_ctrl_test;
    import ctu_pkg::*;
    //------------------------------------------------------------
    // Signals, bus helpers and checking
    //------------------------------------------------------------
    localparam logic [31:0] CFG = 32'h0000cccc; // Both edges on pins
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, seen;
    logic edge_pin_one = 1'b0, edge_pin_two = 1'b0;
    logic first_comparator = 1'b0, first_output_compare = 1'b0;
    logic idle_mode = 1'b0, adc_sampling = 1'b0;
    logic current_source_on, source_ground, discharge_sink;
    logic conv_start, delay_gen_mode, irq;
    int n_mismatch = 0, total_checks = 0;

    ctu_edge_ctrl dut
    (
        .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .edge_pin_one, .edge_pin_two,
        .first_comparator, .first_output_compare, .idle_mode,
        .adc_sampling, .current_source_on, .source_ground,
        .discharge_sink, .conv_start, .delay_gen_mode, .irq
    );

    // Free running clock
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One APB transfer: setup, then access until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Wait for ready; only the watchdog ends a hung transfer
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Watch eight cycles for a conversion request
    task scan_conv;
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge ref_clk);
            if (conv_start === 1'b1)
                seen = 1'b1;
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task t_reset;
        rdc(CTU_CTRL_OFF, 32'h0);
        rdc(CTU_EDGE_OFF, 32'h0);
        rdc(CTU_STAT_OFF, 32'h0);
        rdc(8'h14, 32'h0);
        chk(err, 1'b1);
        $display("reset test done");
    endtask

    task t_order;
        wr(CTU_EDGE_OFF, CFG);
        wr(CTU_CTRL_OFF, 32'h8d00);
        edge_pin_two <= 1'b1;
        tick(4);
        rdc(CTU_EDGE_OFF, CFG);
        edge_pin_one <= 1'b1;
        edge_pin_two <= 1'b0;
        tick(4);
        rdc(CTU_EDGE_OFF, CFG | 32'h100);
        edge_pin_two <= 1'b1;
        scan_conv();
        chk(seen, 1'b1);
        rdc(CTU_EDGE_OFF, CFG | 32'h300);
        $display("order test done");
    endtask

    task t_irq;
        wr(CTU_IEN_OFF, 32'h4);
        tick(3);
        chk(irq, 1'b1);
        wr(CTU_CLR_OFF, 32'h4);
        tick(3);
        chk(irq, 1'b0);
        rdc(CTU_STAT_OFF, 32'h3);
        $display("interrupt test done");
    endtask

    task t_unordered;
        edge_pin_one <= 1'b0;
        edge_pin_two <= 1'b0;
        wr(CTU_CTRL_OFF, 32'h8800);
        wr(CTU_EDGE_OFF, CFG);
        edge_pin_two <= 1'b1;
        tick(4);
        rdc(CTU_EDGE_OFF, CFG | 32'h200);
        edge_pin_one <= 1'b1;
        scan_conv();
        chk(seen, 1'b0);
        rdc(CTU_EDGE_OFF, CFG | 32'h300);
        $display("unordered test done");
    endtask

    task t_soft;
        edge_pin_one <= 1'b0;
        edge_pin_two <= 1'b0;
        wr(CTU_CTRL_OFF, 32'h8000);
        wr(CTU_EDGE_OFF, CFG);
        edge_pin_one <= 1'b1;
        tick(4);
        rdc(CTU_EDGE_OFF, CFG);
        wr(CTU_EDGE_OFF, CFG | 32'h100);
        rdc(CTU_EDGE_OFF, CFG | 32'h100);
        chk(current_source_on, 1'b1);
        adc_sampling <= 1'b1;
        wr(CTU_CTRL_OFF, 32'h8200);
        tick(3);
        chk(source_ground, 1'b1);
        chk(current_source_on, 1'b0);
        chk(discharge_sink, 1'b1);
        adc_sampling <= 1'b0;
        tick(3);
        chk(discharge_sink, 1'b0);
        // Delay mode needs the comparator as edge two source
        wr(CTU_EDGE_OFF, 32'h0000ccd0);
        wr(CTU_CTRL_OFF, 32'h1000);
        tick(3);
        chk(source_ground, 1'b0);
        chk(delay_gen_mode, 1'b1);
        $display("software edge test done");
    endtask

    task t_idle;
        edge_pin_one <= 1'b0;
        idle_mode <= 1'b1;
        wr(CTU_CTRL_OFF, 32'ha800);
        wr(CTU_EDGE_OFF, CFG);
        edge_pin_one <= 1'b1;
        tick(4);
        rdc(CTU_EDGE_OFF, CFG);
        edge_pin_one <= 1'b0;
        wr(CTU_CTRL_OFF, 32'h8800);
        edge_pin_one <= 1'b1;
        tick(4);
        rdc(CTU_EDGE_OFF, CFG | 32'h100);
        idle_mode <= 1'b0;
        $display("idle test done");
    endtask

    // Each second edge source code against its own input
    task t_codes;
        logic [3:0] codes [5] = '{4'h4, 4'h3, 4'h2, 4'h1, 4'hf};
        for (int i = 0; i < 5; i++)
        begin
            {first_comparator, edge_pin_two, edge_pin_one,
                first_output_compare} <= 4'h0;
            wr(CTU_CTRL_OFF, 32'h8800);
            // Edge one on a reserved source with high polarity stays idle
            wr(CTU_EDGE_OFF, 32'h40c0 | {26'h0, codes[i], 2'b00});
            {first_comparator, edge_pin_two, edge_pin_one,
                first_output_compare} <= 4'h8 >> i;
            tick(4);
            rdc(CTU_EDGE_OFF, 32'h42c0 | {26'h0, codes[i], 2'b00});
        end
        $display("source code test done");
    endtask

    // Level-kind low-active edge one, falling edge two
    task t_level;
        edge_pin_one <= 1'b0;
        edge_pin_two <= 1'b1;
        wr(CTU_CTRL_OFF, 32'h8800);
        wr(CTU_EDGE_OFF, 32'h0c8c);
        tick(2);
        rdc(CTU_EDGE_OFF, 32'h0d8c);
        chk(current_source_on, 1'b1);
        wr(CTU_EDGE_OFF, 32'h0c8c);
        rdc(CTU_EDGE_OFF, 32'h0d8c);
        edge_pin_two <= 1'b0;
        tick(2);
        rdc(CTU_EDGE_OFF, 32'h0f8c);
        chk(current_source_on, 1'b0);
        $display("level test done");
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_order();
        t_irq();
        t_unordered();
        t_soft();
        t_idle();
        t_codes();
        t_level();
        summarize();
    end

    // Watchdog against a hung handshake
    initial
    begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule

bind ctu_edge_ctrl ctu_edge_ctrl_properties chk
(
    .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pready,
    .pslverr, .adc_sampling, .current_source_on, .source_ground,
    .discharge_sink, .conv_start, .delay_gen_mode
);
